// ==== common/rtc_pkg.sv ====
// rtc_pkg: constants, carriers and calendar helpers of the calendar clock
package rtc_pkg;
   localparam int RTC_NSW = 32'h3;
   localparam int RTC_CLK_HZ = 32'h017D_7840;
   localparam int RTC_TICK_MS = 32'h1;
   localparam int RTC_TICK_CYC = RTC_CLK_HZ / 32'h3E8 * RTC_TICK_MS;
   localparam logic [9:0] RTC_MS_LAST = 10'h3E7;
   localparam logic [5:0] RTC_SEC_LAST = 6'h3B;
   localparam logic [5:0] RTC_MIN_LAST = 6'h3B;
   localparam logic [4:0] RTC_HOUR_LAST = 5'h17;
   localparam logic [11:0] RTC_EPOCH_YEAR = 12'h7B2;
   localparam int RTC_EPOCH_LEAPS = 32'h1DD;
   localparam logic [2:0] RTC_EPOCH_WDAY = 3'h3;
   localparam logic [26:0] RTC_MS_PER_MIN = 27'h000_EA60;
   localparam logic [26:0] RTC_MS_PER_SEC = 27'h000_03E8;
   // register byte offsets
   localparam logic [7:0] RTC_A_TIME = 8'h00;
   localparam logic [7:0] RTC_A_DATE = 8'h04;
   localparam logic [7:0] RTC_A_DST = 8'h08;
   localparam logic [7:0] RTC_A_DST_DIFF = 8'h0C;
   localparam logic [7:0] RTC_A_WDAY = 8'h10;
   localparam logic [7:0] RTC_A_ALARM_EN = 8'h14;
   localparam logic [7:0] RTC_A_UNLOCK = 8'h18;
   localparam logic [7:0] RTC_A_CMD = 8'h1C;
   localparam logic [7:0] RTC_A_STAMP_D = 8'h20;
   localparam logic [7:0] RTC_A_STAMP_MS = 8'h24;
   localparam logic [7:0] RTC_A_SW_STAT = 8'h28;
   localparam logic [7:0] RTC_A_ROUTE = 8'h2C;
   localparam logic [7:0] RTC_A_IRQ_STAT = 8'h30;
   localparam logic [7:0] RTC_A_IRQ_MASK = 8'h34;
   localparam logic [7:0] RTC_A_SW_BASE = 8'h40;
   localparam logic [7:0] RTC_A_SW_STEP = 8'h08;
   localparam logic [7:0] RTC_A_SW_TIMES = 8'h04;
   // field positions
   localparam int RTC_F_HOUR = 32'h0;
   localparam int RTC_F_MIN = 32'h8;
   localparam int RTC_F_SEC = 32'h10;
   localparam int RTC_F_DAY = 32'h0;
   localparam int RTC_F_MONTH = 32'h8;
   localparam int RTC_F_YEAR = 32'h10;
   localparam int RTC_F_DST_EN = 32'h0;
   localparam int RTC_F_DST_DIFF = 32'h8;
   localparam int RTC_F_ON = 32'h0;
   localparam int RTC_F_OFF = 32'h10;
   localparam int RTC_F_RESTORE = 32'h0;
   localparam int RTC_ROUTE_W = 32'h3;
   // interrupt status bits
   localparam int RTC_IRQ_STAMP = 32'h0;
   localparam int RTC_IRQ_ALARM = 32'h1;
   localparam int RTC_IRQ_SWITCH = 32'h2;
   localparam int RTC_IRQ_W = 32'h3;
   // reset and factory values
   localparam logic [15:0] RTC_DST_RST = 16'h0000;
   localparam logic RTC_ALARM_EN_RST = 1'b1;
   localparam logic RTC_UNLOCK_RST = 1'b0;
   localparam logic [4:0] RTC_DAY_RST = 5'h01;
   localparam logic [3:0] RTC_MONTH_RST = 4'h1;

   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] minute;
   } rtc_hm_t;

   typedef struct packed {
      logic [11:0] year;
      logic [3:0] month;
      logic [4:0] day;
   } rtc_date_t;

   typedef struct packed {
      logic [6:0] day_mask;
      rtc_hm_t on_time;
      rtc_hm_t off_time;
   } rtc_sw_cfg_t;

   function automatic logic rtc_is_leap(input logic [11:0] y);
      return (y[1:0] == 2'h0 && (y % 12'h064) != 12'h000) ||
         (y % 12'h190) == 12'h000;
   endfunction : rtc_is_leap

   function automatic logic [4:0] rtc_month_days(input rtc_date_t d);
      unique case (d.month)
         4'h2: return rtc_is_leap(d.year) ? 5'h1D : 5'h1C;
         4'h4, 4'h6, 4'h9, 4'hB: return 5'h1E;
         default: return 5'h1F;
      endcase
   endfunction : rtc_month_days

   function automatic logic [19:0] rtc_epoch_days(input rtc_date_t d);
      int y;
      int cum;
      y = int'(d.year) - 32'h1;
      unique case (d.month)
         4'h2: cum = 32'h01F;
         4'h3: cum = 32'h03B;
         4'h4: cum = 32'h05A;
         4'h5: cum = 32'h078;
         4'h6: cum = 32'h097;
         4'h7: cum = 32'h0B5;
         4'h8: cum = 32'h0D4;
         4'h9: cum = 32'h0F3;
         4'hA: cum = 32'h111;
         4'hB: cum = 32'h130;
         4'hC: cum = 32'h14E;
         default: cum = 32'h0;
      endcase
      if (d.month > 4'h2 && rtc_is_leap(d.year)) cum = cum + 32'h1;
      return 20'((int'(d.year) - int'(RTC_EPOCH_YEAR)) * 32'h16D
         + y / 32'h4 - y / 32'h64 + y / 32'h190 - RTC_EPOCH_LEAPS
         + cum + int'(d.day) - 32'h1);
   endfunction : rtc_epoch_days
endpackage : rtc_pkg

// ==== tb/rtc_calendar_clock_tb_top.sv ====
// rtc_calendar_clock_tb_top: directed register-level bench for the clock
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar_clock_tb_top import rtc_pkg::*;;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ev = 1'b0;
   logic [31:0] rdata;
   logic [5:0] stat;
   logic [3:0] sink;
   logic alarm;
   logic strobe;
   logic irq;
   logic [19:0] days;
   logic [26:0] ms;
   logic [31:0] d;
   logic [31:0] msk [3] = '{32'h0000_0004, 32'h0000_0002, 32'h0000_0001};
   logic [31:0] tms [3] = '{32'h0002_0001, 32'h1E01_0017, 32'h0002_0001};
   int n_errors = 0;
   int check_count = 0;

   always #20 clk = ~clk;

   rtc_calendar_clock #(.MS_CYCLES(4), .N_SINKS(4)) dut (
      .i_ref_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_msg_event(ev),
      .o_switch_output_status(stat), .o_sink(sink),
      .o_clock_alarm_message(alarm), .o_stamp_days(days), .o_stamp_ms(ms),
      .o_stamp_strobe(strobe), .o_irq(irq));

   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask : chk

   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task pulse_event();
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      #1;
   endtask : pulse_event

   task report_and_stop();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd_reg(RTC_A_DATE, d);
      chk(d, 32'h07B2_0101);
      rd_reg(RTC_A_DST, d);
      chk(d, 32'h0000_0000);
      rd_reg(RTC_A_ALARM_EN, d);
      chk(d, 32'h0000_0001);
      rd_reg(RTC_A_WDAY, d);
      chk(d, 32'h0000_0003);
      chk(32'(alarm), 32'h0000_0001);
      wr_reg(RTC_A_IRQ_MASK, 32'h0000_0001);
      pulse_event();
      chk(32'(strobe), 32'h0000_0001);
      chk(32'(days), 32'h0000_0000);
      // ms already counting proves the clock started by itself
      chk(32'(ms != 27'h0), 32'h0000_0001);
      @(posedge clk);
      #1 chk({strobe, irq}, 32'h0000_0001);
      rd_reg(RTC_A_IRQ_STAT, d);
      chk(d & 32'h1, 32'h0000_0001);
      wr_reg(RTC_A_IRQ_STAT, 32'h0000_0007);
      @(posedge clk);
      #1 chk(32'(irq), 32'h0000_0000);
      // daylight offset of 60 min must not reach the stamp
      wr_reg(RTC_A_DST, 32'h0000_3C01);
      wr_reg(RTC_A_TIME, 32'h0002_0001);
      wr_reg(RTC_A_DATE, 32'h07D9_0C02);
      rd_reg(RTC_A_DST_DIFF, d);
      chk(d, 32'h0000_003C);
      // setting the time clears the clock alarm
      chk(32'(alarm), 32'h0000_0000);
      rd_reg(RTC_A_WDAY, d);
      chk(d, 32'h0000_0002);
      rd_reg(RTC_A_TIME, d);
      chk(d & 32'h1F3F, 32'h0000_0001);
      pulse_event();
      chk(32'(days), 32'h0000_38F4);
      chk(32'(ms) / 32'h3E8, 32'h0000_0E12);
      rd_reg(RTC_A_STAMP_D, d);
      chk(d, 32'h0000_38F4);
      wr_reg(RTC_A_ALARM_EN, 32'h0000_0000);
      wr_reg(RTC_A_CMD, 32'h0000_0001);
      rd_reg(RTC_A_DST, d);
      chk(d, 32'h0000_0000);
      rd_reg(RTC_A_ALARM_EN, d);
      chk(d, 32'h0000_0001);
      rd_reg(RTC_A_DATE, d);
      chk(d, 32'h07D9_0C02);
      // sw0 plain window, sw1 wraps from Tuesday, sw2 day not enabled
      for (int k = 0; k < 3; k++) begin
         wr_reg(RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP, msk[k]);
         wr_reg(RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP + RTC_A_SW_TIMES,
            tms[k]);
      end
      rd_reg(RTC_A_SW_BASE + RTC_A_SW_STEP, d);
      chk(d, 32'h0000_0002);
      rd_reg(8'h4C, d);
      chk(d, 32'h1E01_0017);
      wr_reg(RTC_A_ROUTE, 32'h0000_0CA1);
      rd_reg(RTC_A_SW_STAT, d);
      chk(d, 32'h0000_0000);
      wr_reg(RTC_A_UNLOCK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      rd_reg(RTC_A_SW_STAT, d);
      chk(d, 32'h0000_0025);
      chk(32'(stat), 32'h0000_0025);
      chk(32'(sink), 32'h0000_000D);
      // remaining route codes: sw2 normal, sw1 inverse, 7 and 0 idle
      wr_reg(RTC_A_ROUTE, 32'h0000_01EB);
      repeat (2) @(posedge clk);
      #1 chk(32'(sink), 32'h0000_0000);
      wr_reg(RTC_A_UNLOCK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      #1 chk(32'(stat), 32'h0000_0000);
      // last second of the year rolls date, time and weekday
      wr_reg(RTC_A_TIME, 32'h003B_3B17);
      wr_reg(RTC_A_DATE, 32'h07D9_0C1F);
      repeat (4010) @(posedge clk);
      rd_reg(RTC_A_DATE, d);
      chk(d, 32'h07DA_0101);
      rd_reg(RTC_A_TIME, d);
      chk(d, 32'h0000_0000);
      rd_reg(RTC_A_WDAY, d);
      chk(d, 32'h0000_0004);
      report_and_stop();
   end

   // the sequence needs some 4100 cycles; allow more than twice that
   initial begin
      #400000;
      n_errors++;
      report_and_stop();
   end
endmodule : rtc_calendar_clock_tb_top
`default_nettype wire

// ==== verilog/rtc_calendar_clock.sv ====
// rtc_calendar_clock: calendar clock, event stamps, three weekly switches
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar_clock
   import rtc_pkg::*;
#(
   parameter int MS_CYCLES = RTC_TICK_CYC,
   parameter int N_SINKS = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_msg_event,
   output logic [2*RTC_NSW-1:0] o_switch_output_status,
   output logic [N_SINKS-1:0] o_sink,
   output logic o_clock_alarm_message,
   output logic [19:0] o_stamp_days,
   output logic [26:0] o_stamp_ms,
   output logic o_stamp_strobe,
   output logic o_irq
);
   localparam int DIV_W = $clog2(MS_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

   logic [DIV_W-1:0] div_cnt;
   logic ms_tick;
   logic [9:0] ms_cnt;
   logic [5:0] sec;
   rtc_hm_t now;
   rtc_date_t date;
   logic day_roll;
   logic [19:0] next_days;
   logic [26:0] ms_of_day;
   logic [2:0] weekday;
   logic [15:0] dst_cfg;
   logic [7:0] dst_applied;
   logic alarm_en;
   logic time_unset;
   logic unlock;
   rtc_sw_cfg_t sw_cfg [RTC_NSW];
   logic [N_SINKS*RTC_ROUTE_W-1:0] route;
   logic [RTC_IRQ_W-1:0] irq_stat;
   logic [RTC_IRQ_W-1:0] irq_mask;
   logic [RTC_IRQ_W-1:0] irq_set;
   logic [RTC_NSW-1:0] prev_on;
   logic [31:0] next_rdata;
   logic wr_time;
   logic wr_restore;

   function automatic logic wr_at(input logic [7:0] a);
      return i_wr && i_addr == a;
   endfunction : wr_at

   assign wr_time = wr_at(RTC_A_TIME);
   assign wr_restore = wr_at(RTC_A_CMD) && i_wdata[RTC_F_RESTORE];

   ////////////////////////////////////////////////////////////////////
   // millisecond divider, restarted by a time write
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || wr_time) begin
         div_cnt <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (div_cnt == DIV_LAST);
         div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
      end
   end

   assign day_roll = ms_tick && ms_cnt == RTC_MS_LAST &&
      sec == RTC_SEC_LAST && now.minute == RTC_MIN_LAST &&
      now.hour == RTC_HOUR_LAST;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ms_cnt <= '0;
         sec <= '0;
         now <= '0;
      end else if (wr_time) begin
         ms_cnt <= '0;
         sec <= i_wdata[RTC_F_SEC +: 6];
         now.hour <= i_wdata[RTC_F_HOUR +: 5];
         now.minute <= i_wdata[RTC_F_MIN +: 6];
      end else if (ms_tick) begin
         ms_cnt <= (ms_cnt == RTC_MS_LAST) ? '0 : ms_cnt + 10'h001;
         if (ms_cnt == RTC_MS_LAST) begin
            sec <= (sec == RTC_SEC_LAST) ? '0 : sec + 6'h01;
            if (sec == RTC_SEC_LAST) begin
               if (now.minute == RTC_MIN_LAST) begin
                  now.minute <= '0;
                  now.hour <= (now.hour == RTC_HOUR_LAST) ? '0 :
                     now.hour + 5'h01;
               end else begin
                  now.minute <= now.minute + 6'h01;
               end
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         date <= {RTC_EPOCH_YEAR, RTC_MONTH_RST, RTC_DAY_RST};
      end else if (wr_at(RTC_A_DATE)) begin
         date.day <= i_wdata[RTC_F_DAY +: 5];
         date.month <= i_wdata[RTC_F_MONTH +: 4];
         date.year <= i_wdata[RTC_F_YEAR +: 12];
      end else if (day_roll) begin
         if (date.day >= rtc_month_days(date)) begin
            date.day <= RTC_DAY_RST;
            date.month <= (date.month == 4'hC) ? RTC_MONTH_RST :
               date.month + 4'h1;
            if (date.month == 4'hC) date.year <= date.year + 12'h001;
         end else begin
            date.day <= date.day + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // days since epoch and ms of the day
   always_comb begin
      next_days = rtc_epoch_days(date);
      ms_of_day = 27'(now.hour) * 27'h3C * RTC_MS_PER_MIN
         + 27'(now.minute) * RTC_MS_PER_MIN
         + 27'(sec) * RTC_MS_PER_SEC + 27'(ms_cnt);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         weekday <= RTC_EPOCH_WDAY;
      end else begin
         weekday <= 3'((next_days + 20'(RTC_EPOCH_WDAY)) % 20'h7);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_stamp_days <= '0;
         o_stamp_ms <= '0;
         o_stamp_strobe <= 1'b0;
      end else begin
         o_stamp_strobe <= i_msg_event;
         if (i_msg_event) begin
            o_stamp_days <= next_days;
            o_stamp_ms <= ms_of_day;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // restore keeps time and date
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || wr_restore) begin
         dst_cfg <= RTC_DST_RST;
         alarm_en <= RTC_ALARM_EN_RST;
      end else begin
         if (wr_at(RTC_A_DST)) dst_cfg <= i_wdata[15:0];
         if (wr_at(RTC_A_ALARM_EN)) alarm_en <= i_wdata[0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         dst_applied <= '0;
      end else begin
         dst_applied <= dst_cfg[RTC_F_DST_EN] ?
            dst_cfg[RTC_F_DST_DIFF +: 8] : 8'h00;
      end
   end

   // clock alarm stands until the time is first set
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         time_unset <= 1'b1;
         o_clock_alarm_message <= 1'b0;
      end else begin
         if (wr_time) time_unset <= 1'b0;
         o_clock_alarm_message <= alarm_en && time_unset;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // unlock register
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         unlock <= RTC_UNLOCK_RST;
      end else if (wr_at(RTC_A_UNLOCK)) begin
         unlock <= i_wdata[0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         for (int k = 0; k < RTC_NSW; k++) sw_cfg[k] <= '0;
      end else begin
         for (int k = 0; k < RTC_NSW; k++) begin
            if (wr_at(RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP)) begin
               sw_cfg[k].day_mask <= i_wdata[6:0];
            end
            if (wr_at(RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP +
                  RTC_A_SW_TIMES)) begin
               sw_cfg[k].on_time <= {i_wdata[RTC_F_ON +: 5],
                  i_wdata[RTC_F_ON + RTC_F_MIN +: 6]};
               sw_cfg[k].off_time <= {i_wdata[RTC_F_OFF +: 5],
                  i_wdata[RTC_F_OFF + RTC_F_MIN +: 6]};
            end
         end
      end
   end

   for (genvar g = 0; g < RTC_NSW; g++) begin : g_sw
      rtc_time_switch u_sw (
         .i_ref_clk(i_ref_clk),
         .i_srst(i_srst),
         .i_unlock(unlock),
         .i_weekday(weekday),
         .i_now(now),
         .i_cfg(sw_cfg[g]),
         .o_status(o_switch_output_status[2*g +: 2])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // route to any sink
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         route <= '0;
      end else if (wr_at(RTC_A_ROUTE)) begin
         route <= i_wdata[N_SINKS*RTC_ROUTE_W-1:0];
      end
   end

   // code 0 idle, 1..3 normal, 4..6 inverted
   for (genvar s = 0; s < N_SINKS; s++) begin : g_sink
      logic [2:0] sel;
      assign sel = route[s*RTC_ROUTE_W +: RTC_ROUTE_W];
      always_ff @(posedge i_ref_clk) begin
         if (i_srst || sel == 3'h0 || sel == 3'h7) begin
            o_sink[s] <= 1'b0;
         end else if (sel <= 3'h3) begin
            o_sink[s] <= o_switch_output_status[2*(sel-3'h1)];
         end else begin
            o_sink[s] <= o_switch_output_status[2*(sel-3'h4)+1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      irq_set = '0;
      irq_set[RTC_IRQ_STAMP] = i_msg_event;
      irq_set[RTC_IRQ_ALARM] = alarm_en && time_unset &&
         !o_clock_alarm_message;
      for (int k = 0; k < RTC_NSW; k++) begin
         if (o_switch_output_status[2*k] && !prev_on[k]) begin
            irq_set[RTC_IRQ_SWITCH] = 1'b1;
         end
      end
   end

   // a set arriving with its clear wins
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         irq_stat <= '0;
         irq_mask <= '0;
         prev_on <= '0;
         o_irq <= 1'b0;
      end else begin
         for (int k = 0; k < RTC_NSW; k++) begin
            prev_on[k] <= o_switch_output_status[2*k];
         end
         irq_stat <= (irq_stat & ~({RTC_IRQ_W{wr_at(RTC_A_IRQ_STAT)}} &
            i_wdata[RTC_IRQ_W-1:0])) | irq_set;
         if (wr_at(RTC_A_IRQ_MASK)) irq_mask <= i_wdata[RTC_IRQ_W-1:0];
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      next_rdata = '0;
      unique case (i_addr)
         RTC_A_TIME: begin
            next_rdata[RTC_F_HOUR +: 5] = now.hour;
            next_rdata[RTC_F_MIN +: 6] = now.minute;
            next_rdata[RTC_F_SEC +: 6] = sec;
         end
         RTC_A_DATE: begin
            next_rdata[RTC_F_DAY +: 5] = date.day;
            next_rdata[RTC_F_MONTH +: 4] = date.month;
            next_rdata[RTC_F_YEAR +: 12] = date.year;
         end
         RTC_A_DST: next_rdata[15:0] = dst_cfg;
         RTC_A_DST_DIFF: next_rdata[7:0] = dst_applied;
         RTC_A_WDAY: next_rdata[2:0] = weekday;
         RTC_A_ALARM_EN: next_rdata[0] = alarm_en;
         RTC_A_UNLOCK: next_rdata[0] = unlock;
         RTC_A_STAMP_D: next_rdata[19:0] = o_stamp_days;
         RTC_A_STAMP_MS: next_rdata[26:0] = o_stamp_ms;
         RTC_A_SW_STAT: next_rdata[2*RTC_NSW-1:0] = o_switch_output_status;
         RTC_A_ROUTE: next_rdata[N_SINKS*RTC_ROUTE_W-1:0] = route;
         RTC_A_IRQ_STAT: next_rdata[RTC_IRQ_W-1:0] = irq_stat;
         RTC_A_IRQ_MASK: next_rdata[RTC_IRQ_W-1:0] = irq_mask;
         default: begin
            for (int k = 0; k < RTC_NSW; k++) begin
               if (i_addr == RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP) begin
                  next_rdata[6:0] = sw_cfg[k].day_mask;
               end
               if (i_addr == RTC_A_SW_BASE + 8'(k) * RTC_A_SW_STEP +
                     RTC_A_SW_TIMES) begin
                  next_rdata[RTC_F_ON +: 5] = sw_cfg[k].on_time.hour;
                  next_rdata[RTC_F_ON + RTC_F_MIN +: 6] =
                     sw_cfg[k].on_time.minute;
                  next_rdata[RTC_F_OFF +: 5] = sw_cfg[k].off_time.hour;
                  next_rdata[RTC_F_OFF + RTC_F_MIN +: 6] =
                     sw_cfg[k].off_time.minute;
               end
            end
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !i_rd) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   sequence s_unlock_wr;
      i_wr && i_addr == RTC_A_UNLOCK && i_wdata[0];
   endsequence
   sequence s_pairs_inverse;
      (^o_switch_output_status[1:0]) && (^o_switch_output_status[3:2]) &&
         (^o_switch_output_status[5:4]);
   endsequence

   property p_locked_low;
      !unlock |=> o_switch_output_status == 6'h00;
   endproperty
   a_locked_low: assert property (p_locked_low)
      else $error("switch output not low while locked");
   property p_inverse;
      unlock |=> s_pairs_inverse;
   endproperty
   a_inverse: assert property (p_inverse)
      else $error("switch status bits not inverse");
   property p_release;
      s_unlock_wr |=> unlock ##1 s_pairs_inverse;
   endproperty
   a_release: assert property (p_release)
      else $error("unlock write did not release switches");
   property p_runs;
      ms_tick && !wr_time |=> ms_cnt != $past(ms_cnt);
   endproperty
   a_runs: assert property (p_runs)
      else $error("millisecond count did not advance");
   property p_ms_wrap;
      ms_tick && ms_cnt == RTC_MS_LAST && !wr_time |=>
         ms_cnt == 10'h000 && sec != $past(sec);
   endproperty
   a_ms_wrap: assert property (p_ms_wrap)
      else $error("second did not follow millisecond wrap");
   property p_stamp;
      i_msg_event |=> o_stamp_strobe && o_stamp_ms == $past(ms_of_day) &&
         o_stamp_days == $past(next_days);
   endproperty
   a_stamp: assert property (p_stamp)
      else $error("event stamp wrong");
   property p_restore;
      wr_restore |=> alarm_en && dst_cfg == RTC_DST_RST &&
         (date == $past(date) || $past(day_roll));
   endproperty
   a_restore: assert property (p_restore)
      else $error("factory restore wrong");
   property p_dst_off;
      !dst_cfg[RTC_F_DST_EN] |=> dst_applied == 8'h00;
   endproperty
   a_dst_off: assert property (p_dst_off)
      else $error("daylight difference applied while disabled");
   property p_weekday;
      weekday <= 3'h6 && now.hour <= RTC_HOUR_LAST;
   endproperty
   a_weekday: assert property (p_weekday)
      else $error("weekday or hour out of range");
endmodule : rtc_calendar_clock
`default_nettype wire

// ==== verilog/rtc_time_switch.sv ====
// rtc_time_switch: one weekly time switch with normal and inverted output
`timescale 1ns/10ps
`default_nettype none
module rtc_time_switch
   import rtc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_unlock,
   input wire logic [2:0] i_weekday,
   input wire rtc_hm_t i_now,
   input wire rtc_sw_cfg_t i_cfg,
   output logic [1:0] o_status
);
   logic [10:0] now_min;
   logic [10:0] on_min;
   logic [10:0] off_min;
   logic today_en;
   logic yday_en;
   logic active;

   function automatic logic [10:0] to_min(input rtc_hm_t t);
      return 11'(t.hour) * 11'h03C + 11'(t.minute);
   endfunction : to_min

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      now_min = to_min(i_now);
      on_min = to_min(i_cfg.on_time);
      off_min = to_min(i_cfg.off_time);
      today_en = i_cfg.day_mask[i_weekday];
      yday_en = i_cfg.day_mask[(i_weekday == 3'h0) ? 3'h6 : i_weekday - 3'h1];
      if (on_min < off_min) begin
         active = today_en && now_min >= on_min && now_min < off_min;
      end else if (off_min < on_min) begin
         active = (today_en && now_min >= on_min) ||
            (yday_en && now_min < off_min);
      end else begin
         active = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // level evaluation, so a released switch follows its schedule at once
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_status <= 2'h0;
      end else if (!i_unlock) begin
         o_status <= 2'h0;
      end else begin
         o_status <= {~active, active};
      end
   end
endmodule : rtc_time_switch
`default_nettype wire
